/* File: logic/unbalance_function.sv */
// Current unbalance detector with start and delayed trip
`timescale 1ns/1ps
`include "unbalance_map.svh"
module unbalance_function
    import unbalance_pkg::*;
#(
    parameter int unsigned CYCLES_PER_MS = `UB_CYCLES_PER_MS
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    output logic [31:0] o_rdata,
    input wire logic [15:0] i_phase1_rms,
    input wire logic [15:0] i_phase2_rms,
    input wire logic [15:0] i_phase3_rms,
    input wire logic i_user_block_input,
    output logic o_general_start,
    output logic o_general_trip,
    output logic o_start_event,
    output logic o_trip_event
);

    // ****************************************
    // Functions
    // ****************************************
    function automatic logic [23:0] pct_mul(input logic [15:0] v, input logic [7:0] p);
        pct_mul = {8'h00, v} * {16'h0000, p};
    endfunction : pct_mul

    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp16

    // ****************************************
    // Register file
    // ****************************************
    ctrl_s ctrl_q;
    ctrl_s ctrl_d;
    logic [7:0] pct_q;
    logic [7:0] pct_d;
    logic [15:0] delay_q;
    logic [15:0] delay_d;
    logic [15:0] rated_q;
    logic [15:0] rated_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    always_comb begin
        ctrl_d = ctrl_q;
        pct_d = pct_q;
        delay_d = delay_q;
        rated_d = rated_q;
        if (i_write) begin
            case (i_addr)
                `UB_CTRL_ADDR: begin
                    ctrl_d.operation = i_wdata[`UB_CTRL_OPER_BIT];
                    ctrl_d.start_only = i_wdata[`UB_CTRL_SONLY_BIT];
                end
                `UB_PCT_ADDR: begin
                    pct_d = 8'(clamp16(i_wdata[15:0], {8'h00, `UB_PCT_MIN},
                                       {8'h00, `UB_PCT_MAX}));
                end
                `UB_DELAY_ADDR: begin
                    delay_d = clamp16(i_wdata[15:0], `UB_DELAY_MIN, `UB_DELAY_MAX);
                end
                `UB_RATED_ADDR: begin
                    rated_d = i_wdata[15:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // Magnitude processing
    // ****************************************
    phases_s phases;
    flags_s flags_q;
    flags_s flags_d;
    logic [15:0] max_q;
    logic [15:0] max_d;
    logic [15:0] min_q;
    logic [15:0] min_d;

    assign phases = '{phase1_rms: i_phase1_rms, phase2_rms: i_phase2_rms,
                      phase3_rms: i_phase3_rms};

    always_comb begin
        max_d = phases.phase1_rms;
        min_d = phases.phase1_rms;
        if (phases.phase2_rms > max_d) begin
            max_d = phases.phase2_rms;
        end
        if (phases.phase3_rms > max_d) begin
            max_d = phases.phase3_rms;
        end
        if (phases.phase2_rms < min_d) begin
            min_d = phases.phase2_rms;
        end
        if (phases.phase3_rms < min_d) begin
            min_d = phases.phase3_rms;
        end
        flags_d.over_limit = pct_mul(max_d - min_d, `UB_HUNDRED) > pct_mul(max_d, pct_q);
        flags_d.sufficient = pct_mul(max_d, `UB_HUNDRED) > pct_mul(rated_q, `UB_LOW_PCT);
        flags_d.not_fault = pct_mul(max_d, `UB_HUNDRED) < pct_mul(rated_q, `UB_HIGH_PCT);
    end

    // ****************************************
    // Decision logic
    // ****************************************
    logic enabled;
    logic timer_run;
    logic expired;
    logic start_q;
    logic start_d;
    logic trip_q;
    logic trip_d;
    logic start_evt_q;
    logic start_evt_d;
    logic trip_evt_q;
    logic trip_evt_d;

    assign enabled = ctrl_q.operation && !i_user_block_input;
    assign timer_run = enabled && flags_q.over_limit && flags_q.sufficient && flags_q.not_fault;

    unbalance_timer #(
        .CYCLES_PER_MS(CYCLES_PER_MS)
    ) u_timer (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_run(timer_run),
        .i_delay_ms(delay_q),
        .o_expired(expired)
    );

    always_comb begin
        start_d = timer_run;
        trip_d = timer_run && expired && !ctrl_q.start_only;
        start_evt_d = start_d != start_q;
        trip_evt_d = trip_d != trip_q;
    end

    // ****************************************
    // Read port
    // ****************************************
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (i_read) begin
            case (i_addr)
                `UB_CTRL_ADDR: rdata_d = {30'h0000_0000, ctrl_q.start_only, ctrl_q.operation};
                `UB_PCT_ADDR: rdata_d = {24'h00_0000, pct_q};
                `UB_DELAY_ADDR: rdata_d = {16'h0000, delay_q};
                `UB_RATED_ADDR: rdata_d = {16'h0000, rated_q};
                `UB_STATUS_ADDR: rdata_d = {27'h000_0000, flags_q, trip_q, start_q};
                `UB_MAX_ADDR: rdata_d = {16'h0000, max_q};
                `UB_MIN_ADDR: rdata_d = {16'h0000, min_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // State registers
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            ctrl_q <= '{operation: 1'b0, start_only: 1'b0};
            pct_q <= `UB_PCT_RESET;
            delay_q <= `UB_DELAY_RESET;
            rated_q <= `UB_RATED_RESET;
            rdata_q <= 32'h0000_0000;
            flags_q <= '0;
            max_q <= 16'h0000;
            min_q <= 16'h0000;
            start_q <= 1'b0;
            trip_q <= 1'b0;
            start_evt_q <= 1'b0;
            trip_evt_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            pct_q <= pct_d;
            delay_q <= delay_d;
            rated_q <= rated_d;
            rdata_q <= rdata_d;
            flags_q <= flags_d;
            max_q <= max_d;
            min_q <= min_d;
            start_q <= start_d;
            trip_q <= trip_d;
            start_evt_q <= start_evt_d;
            trip_evt_q <= trip_evt_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_general_start = start_q;
    assign o_general_trip = trip_q;
    assign o_start_event = start_evt_q;
    assign o_trip_event = trip_evt_q;

    // ****************************************
    // Assertions
    // ****************************************
    logic [31:0] hold_q;

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || !timer_run) begin
            hold_q <= 32'h0000_0000;
        end else if (hold_q != 32'hFFFF_FFFF) begin
            hold_q <= hold_q + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_reset_n);

    property p_max_min;
        $past(i_reset_n) |-> max_q >= $past(i_phase1_rms) && max_q >= $past(i_phase2_rms)
            && max_q >= $past(i_phase3_rms) && min_q <= $past(i_phase1_rms)
            && min_q <= $past(i_phase2_rms) && min_q <= $past(i_phase3_rms)
            && (max_q == $past(i_phase1_rms) || max_q == $past(i_phase2_rms)
                || max_q == $past(i_phase3_rms))
            && (min_q == $past(i_phase1_rms) || min_q == $past(i_phase2_rms)
                || min_q == $past(i_phase3_rms));
    endproperty
    a_max_min: assert property (p_max_min) else $error("max or min wrong");

    property p_spread;
        $past(i_reset_n) |-> flags_q.over_limit
            == (32'(min_q) * 32'd100 < 32'(max_q) * (32'd100 - 32'($past(pct_q))));
    endproperty
    a_spread: assert property (p_spread) else $error("spread not flagged");

    property p_start_cause;
        o_general_start |-> $past(flags_q.over_limit && flags_q.sufficient && flags_q.not_fault);
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("start without cause");

    property p_disabled;
        (!ctrl_q.operation || i_user_block_input) |=> !o_general_start && !o_general_trip;
    endproperty
    a_disabled: assert property (p_disabled) else $error("output while disabled");

    property p_trip_delay;
        o_general_trip |-> o_general_start && hold_q >= delay_q * CYCLES_PER_MS;
    endproperty
    a_trip_delay: assert property (p_trip_delay) else $error("trip too early");

    property p_start_only;
        ctrl_q.start_only |=> !o_general_trip;
    endproperty
    a_start_only: assert property (p_start_only) else $error("trip in start-only");

    property p_settings;
        pct_q >= `UB_PCT_MIN && pct_q <= `UB_PCT_MAX && delay_q >= `UB_DELAY_MIN
        && delay_q <= `UB_DELAY_MAX;
    endproperty
    a_settings: assert property (p_settings) else $error("setting out of range");

    property p_events;
        o_start_event == $changed(o_general_start) && o_trip_event == $changed(o_general_trip);
    endproperty
    a_events: assert property (p_events) else $error("event mismatch");

    property p_clear;
        !timer_run |=> !o_general_start && !o_general_trip && hold_q == 32'h0000_0000
            && u_timer.ms_q == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) else $error("outputs not cleared");

    c_start: cover property ($rose(o_general_start));
    c_trip: cover property ($rose(o_general_trip));
    c_start_only: cover property (ctrl_q.start_only && o_general_start);
    c_blocked: cover property (o_general_start ##1 i_user_block_input);

endmodule : unbalance_function

/* File: logic/unbalance_map.svh */
// Register offsets, field positions, reset values and timing counts of the unbalance function
`ifndef UNBALANCE_MAP_SVH
`define UNBALANCE_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define UB_CTRL_ADDR 8'h00
`define UB_PCT_ADDR 8'h04
`define UB_DELAY_ADDR 8'h08
`define UB_RATED_ADDR 8'h0C
`define UB_STATUS_ADDR 8'h10
`define UB_MAX_ADDR 8'h14
`define UB_MIN_ADDR 8'h18

// ****************************************
// Field positions
// ****************************************
`define UB_CTRL_OPER_BIT 0
`define UB_CTRL_SONLY_BIT 1

// ****************************************
// Reset values and limits
// ****************************************
`define UB_PCT_MIN 8'h0A
`define UB_PCT_MAX 8'h5A
`define UB_PCT_RESET 8'h32
`define UB_DELAY_MIN 16'h0064
`define UB_DELAY_MAX 16'hEA60
`define UB_DELAY_RESET 16'h03E8
`define UB_RATED_RESET 16'h1000
`define UB_LOW_PCT 8'h0A
`define UB_HIGH_PCT 8'h96
`define UB_HUNDRED 8'h64

// ****************************************
// Timing
// ****************************************
`define UB_CLK_PERIOD_NS 100
`define UB_MS_IN_NS 1000000
`define UB_CYCLES_PER_MS (`UB_MS_IN_NS / `UB_CLK_PERIOD_NS)

`endif

/* File: logic/unbalance_pkg.sv */
// Types shared by the unbalance function
package unbalance_pkg;

    typedef struct packed {
        logic operation;
        logic start_only;
    } ctrl_s;

    typedef struct packed {
        logic over_limit;
        logic sufficient;
        logic not_fault;
    } flags_s;

    typedef struct packed {
        logic [15:0] phase1_rms;
        logic [15:0] phase2_rms;
        logic [15:0] phase3_rms;
    } phases_s;

endpackage : unbalance_pkg

/* File: logic/unbalance_timer.sv */
// Millisecond delay timer restarted whenever its run input drops
`timescale 1ns/1ps
module unbalance_timer #(
    parameter int unsigned CYCLES_PER_MS = 10000
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_run,
    input wire logic [15:0] i_delay_ms,
    output logic o_expired
);

    logic [31:0] prescale_q;
    logic [31:0] prescale_d;
    logic [15:0] ms_q;
    logic [15:0] ms_d;
    logic tick;

    // ****************************************
    // Millisecond enable and elapsed count
    // ****************************************
    assign tick = i_run && (prescale_q == CYCLES_PER_MS - 1);

    always_comb begin
        prescale_d = prescale_q;
        ms_d = ms_q;
        if (!i_run) begin
            prescale_d = 32'h0000_0000;
            ms_d = 16'h0000;
        end else if (tick) begin
            prescale_d = 32'h0000_0000;
            if (ms_q != 16'hFFFF) begin
                ms_d = ms_q + 16'h0001;
            end
        end else begin
            prescale_d = prescale_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            prescale_q <= 32'h0000_0000;
            ms_q <= 16'h0000;
        end else begin
            prescale_q <= prescale_d;
            ms_q <= ms_d;
        end
    end

    assign o_expired = i_run && (ms_q >= i_delay_ms);

endmodule : unbalance_timer

/* File: test/tb_unbalance_function.sv */
// Self-checking testbench of the unbalance function
`timescale 1ns/1ps
`include "unbalance_map.svh"
module tb_unbalance_function
    import unbalance_pkg::*;
;
    logic i_mclk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic i_write = 1'b0;
    logic i_read = 1'b0;
    logic [31:0] o_rdata;
    logic o_general_start;
    logic o_general_trip;
    logic o_start_event;
    logic o_trip_event;
    phases_s phases;
    logic blk;
    int trips;
    int bad_count = 0;
    int checks = 0;

    // ****************************************
    // Clock, far side and design
    // ****************************************
    initial begin
        forever #50 i_mclk = ~i_mclk;
    end
    unbalance_far_side up (.i_mclk(i_mclk), .i_general_trip(o_general_trip),
        .o_phases(phases), .o_user_block_input(blk), .o_trip_count(trips));
    unbalance_function #(.CYCLES_PER_MS(10)) dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
        .o_rdata(o_rdata), .i_phase1_rms(phases.phase1_rms),
        .i_phase2_rms(phases.phase2_rms), .i_phase3_rms(phases.phase3_rms),
        .i_user_block_input(blk), .o_general_start(o_general_start),
        .o_general_trip(o_general_trip), .o_start_event(o_start_event),
        .o_trip_event(o_trip_event));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= d;
        i_write <= 1'b1;
        @(posedge i_mclk);
        i_write <= 1'b0;
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_mclk);
        i_addr <= a;
        i_read <= 1'b1;
        @(posedge i_mclk);
        i_read <= 1'b0;
        #1;
        chk(o_rdata, exp);
    endtask : rc
    task automatic cond(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c,
            input logic exp);
        up.put(a, b, c);
        repeat (3) @(posedge i_mclk);
        #1;
        chk({31'h0, o_general_start}, {31'h0, exp});
    endtask : cond

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic check_regs;
        rc(`UB_CTRL_ADDR, 32'h0000_0000);
        rc(`UB_PCT_ADDR, 32'h0000_0032);
        rc(`UB_DELAY_ADDR, 32'h0000_03E8);
        rc(`UB_STATUS_ADDR, 32'h0000_0004);
        wr(8'h1C, 32'h0000_0003);
        rc(8'h1C, 32'h0000_0000);
        rc(`UB_CTRL_ADDR, 32'h0000_0000);
        wr(`UB_PCT_ADDR, 32'h0000_0005);
        rc(`UB_PCT_ADDR, 32'h0000_000A);
        wr(`UB_PCT_ADDR, 32'h0000_00C8);
        rc(`UB_PCT_ADDR, 32'h0000_005A);
        wr(`UB_DELAY_ADDR, 32'h0000_0032);
        rc(`UB_DELAY_ADDR, 32'h0000_0064);
        wr(`UB_DELAY_ADDR, 32'h0000_FFFF);
        rc(`UB_DELAY_ADDR, 32'h0000_EA60);
        wr(`UB_PCT_ADDR, 32'h0000_0032);
        wr(`UB_DELAY_ADDR, 32'h0000_0064);
        wr(`UB_RATED_ADDR, 32'h0000_03E8);
    endtask : check_regs
    task automatic check_range;
        cond(16'h03E8, 16'h0190, 16'h03E8, 1'b0);
        wr(`UB_CTRL_ADDR, 32'h0000_0001);
        cond(16'h0064, 16'h0064, 16'h0000, 1'b0);
        cond(16'h0065, 16'h0000, 16'h0065, 1'b1);
        cond(16'h05DC, 16'h05DC, 16'h0000, 1'b0);
        cond(16'h0000, 16'h05DB, 16'h05DB, 1'b1);
        cond(16'h0578, 16'h0578, 16'h02BC, 1'b0);
        cond(16'h0578, 16'h02BB, 16'h0578, 1'b1);
        cond(16'h03E8, 16'h03E8, 16'h03E8, 1'b0);
    endtask : check_range
    task automatic check_timing;
        int n;
        int ns;
        int ev;
        n = 0;
        ns = 0;
        ev = 0;
        up.put(16'h0190, 16'h03E8, 16'h03E8);
        while (o_general_trip !== 1'b1) begin
            @(posedge i_mclk);
            #1;
            n++;
            if (o_start_event === 1'b1) begin
                ns = n;
            end
            if (n > 2000) begin
                bad_count++;
                wrap_up();
            end
        end
        chk(ns, 2);
        chk(n, 1002);
        chk({31'h0, o_trip_event}, 32'h0000_0001);
        rc(`UB_STATUS_ADDR, 32'h0000_001F);
        rc(`UB_MAX_ADDR, 32'h0000_03E8);
        rc(`UB_MIN_ADDR, 32'h0000_0190);
        up.put(16'h03E8, 16'h03E8, 16'h03E8);
        repeat (3) begin
            @(posedge i_mclk);
            #1;
            ev += (o_trip_event === 1'b1) + (o_start_event === 1'b1);
        end
        chk(ev, 2);
        chk({30'h0000_0000, o_general_start, o_general_trip}, 32'h0000_0000);
        chk(trips, 32'h0000_0001);
    endtask : check_timing
    task automatic check_block;
        cond(16'h03E8, 16'h0000, 16'h0200, 1'b1);
        repeat (500) @(posedge i_mclk);
        up.block(1'b1);
        repeat (2) @(posedge i_mclk);
        #1;
        chk({30'h0000_0000, o_general_start, o_general_trip}, 32'h0000_0000);
        up.block(1'b0);
        repeat (900) @(posedge i_mclk);
        #1;
        chk({30'h0000_0000, o_general_start, o_general_trip}, 32'h0000_0002);
        cond(16'h03E8, 16'h03E8, 16'h03E8, 1'b0);
    endtask : check_block
    task automatic check_start_only;
        int t0;
        t0 = trips;
        wr(`UB_CTRL_ADDR, 32'h0000_0003);
        up.put(16'h03E8, 16'h0100, 16'h03E8);
        repeat (1100) @(posedge i_mclk);
        #1;
        chk({30'h0000_0000, o_general_start, o_general_trip}, 32'h0000_0002);
        chk(trips, t0);
        wr(`UB_CTRL_ADDR, 32'h0000_0000);
        repeat (3) @(posedge i_mclk);
        #1;
        chk({30'h0000_0000, o_general_start, o_general_trip}, 32'h0000_0000);
    endtask : check_start_only

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (5) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        #1;
        chk({30'h0000_0000, o_general_start, o_general_trip}, 32'h0000_0000);
        check_regs();
        check_range();
        check_timing();
        check_block();
        check_start_only();
        wrap_up();
    end
endmodule : tb_unbalance_function

/* File: test/unbalance_far_side.sv */
// Far-side model: phase RMS source, user blocking logic and downstream trip counter
`timescale 1ns/1ps
module unbalance_far_side
    import unbalance_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_general_trip,
    output phases_s o_phases,
    output logic o_user_block_input,
    output int o_trip_count
);
    logic trip_q;
    initial begin
        o_phases = '0;
        o_user_block_input = 1'b0;
        o_trip_count = 0;
        trip_q = 1'b0;
    end
    // Hands over RMS magnitudes only, never raw samples
    task automatic put(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        @(posedge i_mclk);
        o_phases <= {a, b, c};
    endtask : put
    // Level from user logic that disables the function
    task automatic block(input logic lvl);
        @(posedge i_mclk);
        o_user_block_input <= lvl;
    endtask : block
    // Downstream logic counts trip commands
    always @(posedge i_mclk) begin
        trip_q <= i_general_trip;
        if (i_general_trip && !trip_q) begin
            o_trip_count <= o_trip_count + 1;
        end
    end
endmodule : unbalance_far_side
